/* File: inc/fds_pkg.sv */
// Package: register map, field positions and codes of the disk status block
package fds_pkg;

    // Register byte offsets on APB
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_DATA   = 12'h004;
    localparam logic [11:0] OFF_ADDR   = 12'h008;
    localparam logic [11:0] OFF_ISTAT  = 12'h00C;
    localparam logic [11:0] OFF_IMASK  = 12'h010;

    // Control register fields
    localparam int CTL_ERR     = 15;
    localparam int CTL_DONE    = 7;
    localparam int CTL_IEN     = 6;
    localparam int CTL_UNIT    = 4;
    localparam int CTL_FUNC_HI = 3;
    localparam int CTL_FUNC_LO = 1;
    localparam int CTL_GO      = 0;

    // Status word fields
    localparam int ST_READY   = 7;
    localparam int ST_DELETED = 5;
    localparam int ST_MISSING = 4;
    localparam int ST_CRC     = 3;
    localparam int ST_LOST    = 2;
    localparam int ST_BADLOC  = 1;
    localparam int ST_INIT    = 0;

    // Address register fields
    localparam int ADR_TRK_HI = 14;
    localparam int ADR_TRK_LO = 8;
    localparam int ADR_SEC_HI = 4;
    localparam int ADR_SEC_LO = 0;

    // Valid address range: tracks 0..76, sectors 1..26
    localparam logic [6:0] TRACK_MAX  = 7'h4C;
    localparam logic [4:0] SECTOR_MIN = 5'h01;
    localparam logic [4:0] SECTOR_MAX = 5'h1A;

    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR  = 1;

    // Reset values
    localparam logic [15:0] CTRL_RESET = 16'h0080;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [1:0]  IRQ_RESET  = 2'h0;

    // Function codes
    typedef enum logic [2:0] {
        FN_FILL    = 3'h0,
        FN_EMPTY   = 3'h1,
        FN_WRITE   = 3'h2,
        FN_READ    = 3'h3,
        FN_INIT    = 3'h4,
        FN_STATUS  = 3'h5,
        FN_WRDEL   = 3'h6,
        FN_RESTORE = 3'h7
    } fds_func_t;

    // Sequencer states
    typedef enum logic [0:0] {
        SQ_IDLE = 1'b0,
        SQ_BUSY = 1'b1
    } fds_state_t;

endpackage

/* File: hdl/fds_regs.sv */
// Data buffer, error status and track/sector registers of the disk interface
//
// Notes on behaviour
// - Disk data passes the data buffer only as whole 16-bit words.
// - Drive-ready sets only if drive present, powered, disk in, door shut, up to speed; the code checks only present, powered and spun up.
// - Function on a not-ready drive sets error summary and done.
// - Ready status is captured only by read status or initialize (drive 0).
// - Deleted data mark seen while reading sets status bit 05.
// - Record not found in two revolutions sets bit 04, error and done.
// - Checksum mismatch on read data sets bit 03, error and done.
// - Data request not serviced in one byte time sets bit 02, error, done.
// - Track or sector out of range sets bit 01, error and done.
// - Completed initialize sets status bit 00.
// - At function end the status word replaces data in the data buffer; the code does this for all functions but fill and empty.
// - Address register bits 14-08 hold track, range 0 to 76.
// - Address bits 04-00 hold sector 1 to 26; bits 15, 07-05 read zero.
// - Control bits 03-01 select one of eight functions, write-only.
// - Writing go as one launches the function on the selected unit.
// - Interrupt enable bit 06 requests interrupt at done; cleared by reset.
// - Good initialize clears error and status, sets ready and init done.
`timescale 1ns/1ps

module fds_regs
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Drive condition, one bit per unit
    input  wire logic [1:0]  drv_present,
    input  wire logic [1:0]  drv_powered,
    input  wire logic [1:0]  drv_spun_up,
    // Drive operation handshake
    output logic             op_start,
    output logic [2:0]       op_code,
    output logic             op_unit,
    output logic [6:0]       op_track,
    output logic [4:0]       op_sector,
    input  wire logic        op_done,
    input  wire logic        op_deleted,
    input  wire logic        op_not_found,
    input  wire logic        op_crc_bad,
    input  wire logic        op_lost_data,
    // Word stream to and from the drive side
    output logic             wr_word_valid,
    output logic [15:0]      wr_word,
    input  wire logic        rd_word_valid,
    input  wire logic [15:0] rd_word,
    // Interrupt
    output logic             irq
);

    // Status word assembly from individual flags
    function automatic logic [15:0] pack_status(
        input logic rdy, input logic del, input logic miss,
        input logic crc, input logic lost, input logic badl,
        input logic init);
        logic [15:0] w;
        w = 16'h0000;
        w[fds_pkg::ST_READY]   = rdy;
        w[fds_pkg::ST_DELETED] = del;
        w[fds_pkg::ST_MISSING] = miss;
        w[fds_pkg::ST_CRC]     = crc;
        w[fds_pkg::ST_LOST]    = lost;
        w[fds_pkg::ST_BADLOC]  = badl;
        w[fds_pkg::ST_INIT]    = init;
        return w;
    endfunction

    fds_pkg::fds_state_t state_q;
    fds_pkg::fds_state_t state_d;

    logic        err_q;
    logic        done_q;
    logic        ien_q;
    logic        unit_q;
    logic [2:0]  func_q;
    logic [15:0] data_q;
    logic [15:0] stat_q;
    logic [15:0] stat_d;
    logic [6:0]  track_q;
    logic [4:0]  sector_q;
    logic [1:0]  ist_q;
    logic [1:0]  imask_q;
    logic        ready_cap_q;
    logic        op_start_q;
    logic        wr_valid_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        irq_q;

    // Bus decode; access completes one cycle after setup
    wire setup_ph  = psel & ~penable & ~pready_q;
    wire access_ok = psel & penable & pready_q;
    wire hit_ctrl  = paddr == fds_pkg::OFF_CTRL;
    wire hit_data  = paddr == fds_pkg::OFF_DATA;
    wire hit_addr  = paddr == fds_pkg::OFF_ADDR;
    wire hit_ist   = paddr == fds_pkg::OFF_ISTAT;
    wire hit_imask = paddr == fds_pkg::OFF_IMASK;
    wire hit_any   = hit_ctrl | hit_data | hit_addr | hit_ist | hit_imask;
    // A partial write would split a word, so it is refused
    wire strb_bad  = pwrite & (pstrb[1:0] != 2'h3);
    wire slv_err   = ~hit_any | strb_bad;
    wire wr_ok     = access_ok & pwrite & ~pslverr_q;
    wire rd_ok     = access_ok & ~pwrite & ~pslverr_q;

    // Register writes
    wire wr_ctrl  = wr_ok & hit_ctrl;
    wire wr_data  = wr_ok & hit_data;
    wire wr_addr  = wr_ok & hit_addr;
    wire wr_imask = wr_ok & hit_imask;
    wire rd_ist   = rd_ok & hit_ist;

    // Launch decode
    wire [2:0] new_func = pwdata[fds_pkg::CTL_FUNC_HI:fds_pkg::CTL_FUNC_LO];
    wire       new_unit = pwdata[fds_pkg::CTL_UNIT];
    wire       go       = wr_ctrl & pwdata[fds_pkg::CTL_GO]
                          & (state_q == fds_pkg::SQ_IDLE);

    // Drive readiness of each unit
    wire [1:0] unit_rdy = drv_present & drv_powered & drv_spun_up;
    wire       sel_rdy  = unit_rdy[new_unit];

    // Buffer-only functions need no drive
    wire buf_only = (new_func == fds_pkg::FN_FILL)
                  | (new_func == fds_pkg::FN_EMPTY);
    wire needs_adr = (new_func == fds_pkg::FN_WRITE)
                   | (new_func == fds_pkg::FN_READ)
                   | (new_func == fds_pkg::FN_WRDEL);
    wire trk_bad   = track_q > fds_pkg::TRACK_MAX;
    wire sec_bad   = (sector_q < fds_pkg::SECTOR_MIN)
                   | (sector_q > fds_pkg::SECTOR_MAX);
    wire go_notrdy = go & ~buf_only & ~sel_rdy;
    wire go_badloc = go & sel_rdy & needs_adr & (trk_bad | sec_bad);
    wire go_reject = go_notrdy | go_badloc;
    wire go_status = go & sel_rdy & (new_func == fds_pkg::FN_STATUS);
    wire go_drive  = go & ~buf_only & ~go_reject & ~go_status;
    wire go_buffer = go & buf_only;

    // Completion of a drive operation
    wire busy_end  = (state_q == fds_pkg::SQ_BUSY) & op_done;
    wire end_err   = op_not_found | op_crc_bad | op_lost_data
                   | (op_deleted & (func_q == fds_pkg::FN_READ));
    wire end_init  = busy_end & (func_q == fds_pkg::FN_INIT);
    wire finish    = busy_end | go_reject | go_status | go_buffer;
    wire finish_er = (busy_end & end_err) | go_reject;

    // Status word next value
    always_comb
    begin
        stat_d = stat_q;
        // Old ready is kept only while the newly selected unit is ready
        if (go & ~buf_only)
        begin
            stat_d = pack_status(ready_cap_q & sel_rdy, 1'b0, 1'b0,
                                 1'b0, 1'b0, 1'b0, 1'b0);
        end
        if (go_badloc)
        begin
            stat_d[fds_pkg::ST_BADLOC] = 1'b1;
        end
        if (go_status)
        begin
            stat_d[fds_pkg::ST_READY] = sel_rdy;
        end
        if (busy_end)
        begin
            if (func_q == fds_pkg::FN_READ)
            begin
                stat_d[fds_pkg::ST_DELETED] = op_deleted;
            end
            stat_d[fds_pkg::ST_MISSING] = op_not_found;
            stat_d[fds_pkg::ST_CRC]     = op_crc_bad;
            stat_d[fds_pkg::ST_LOST]    = op_lost_data;
        end
        if (end_init & ~end_err)
        begin
            stat_d = pack_status(unit_rdy[0], 1'b0, 1'b0, 1'b0,
                                 1'b0, 1'b0, 1'b1);
        end
    end

    // Sequencer next state
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            fds_pkg::SQ_IDLE:
                if (go_drive)
                begin
                    state_d = fds_pkg::SQ_BUSY;
                end
            fds_pkg::SQ_BUSY:
                if (op_done)
                begin
                    state_d = fds_pkg::SQ_IDLE;
                end
        endcase
    end

    // Sequencer state, status word and captured ready registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q     <= fds_pkg::SQ_IDLE;
            stat_q      <= fds_pkg::WORD_RESET;
            ready_cap_q <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            stat_q      <= stat_d;
            ready_cap_q <= stat_d[fds_pkg::ST_READY];
        end
    end

    // Control register; done clears at launch, sets at finish
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            err_q  <= fds_pkg::CTRL_RESET[fds_pkg::CTL_ERR];
            done_q <= fds_pkg::CTRL_RESET[fds_pkg::CTL_DONE];
            ien_q  <= fds_pkg::CTRL_RESET[fds_pkg::CTL_IEN];
            unit_q <= fds_pkg::CTRL_RESET[fds_pkg::CTL_UNIT];
            func_q <= fds_pkg::FN_FILL;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ien_q <= pwdata[fds_pkg::CTL_IEN];
                if (state_q == fds_pkg::SQ_IDLE)
                begin
                    unit_q <= new_unit;
                end
            end
            if (go)
            begin
                func_q <= new_func;
                err_q  <= 1'b0;
                done_q <= 1'b0;
            end
            if (finish)
            begin
                done_q <= 1'b1;
                err_q  <= finish_er;
            end
        end
    end

    // Data buffer: words in and out, status word at the end of every function but fill and empty
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_q     <= fds_pkg::WORD_RESET;
            wr_valid_q <= 1'b0;
        end
        else
        begin
            wr_valid_q <= wr_data;
            if (finish & ~go_buffer)
            begin
                data_q <= stat_d;
            end
            else if (wr_data)
            begin
                data_q <= pwdata[15:0];
            end
            else if (rd_word_valid)
            begin
                data_q <= rd_word;
            end
        end
    end

    // Track and sector register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            track_q  <= fds_pkg::WORD_RESET[6:0];
            sector_q <= fds_pkg::WORD_RESET[4:0];
        end
        else if (wr_addr)
        begin
            track_q  <= pwdata[fds_pkg::ADR_TRK_HI:fds_pkg::ADR_TRK_LO];
            sector_q <= pwdata[fds_pkg::ADR_SEC_HI:fds_pkg::ADR_SEC_LO];
        end
    end

    // Drive command outputs; address follows the track and sector register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_start_q <= 1'b0;
        end
        else
        begin
            op_start_q <= go_drive;
        end
    end

    // Sticky interrupt events; a set in the read cycle is kept
    wire [1:0] ev = {finish & finish_er, finish & ien_q};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ist_q   <= fds_pkg::IRQ_RESET;
            imask_q <= fds_pkg::IRQ_RESET;
            irq_q   <= 1'b0;
        end
        else
        begin
            ist_q <= (rd_ist ? 2'h0 : ist_q) | ev;
            if (wr_imask)
            begin
                imask_q <= pwdata[1:0];
            end
            irq_q <= |(ist_q & imask_q);
        end
    end

    // Read mux
    wire [15:0] ctrl_rd = {err_q, 7'h00, done_q, ien_q, 1'b0,
                           unit_q, 4'h0};
    wire [15:0] addr_rd = {1'b0, track_q, 3'h0, sector_q};
    wire [31:0] rd_mux  = hit_ctrl  ? {16'h0000, ctrl_rd} :
                          hit_data  ? {16'h0000, data_q}  :
                          hit_addr  ? {16'h0000, addr_rd} :
                          hit_ist   ? {30'h0, ist_q}      :
                          hit_imask ? {30'h0, imask_q}    : 32'h0;

    // APB answer: one access cycle, no waits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end
        else
        begin
            pready_q  <= setup_ph;
            pslverr_q <= setup_ph & slv_err;
            prdata_q  <= (setup_ph & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign op_start      = op_start_q;
    assign op_code       = func_q;
    assign op_unit       = unit_q;
    assign op_track      = track_q;
    assign op_sector     = sector_q;
    assign wr_word_valid = wr_valid_q;
    assign wr_word       = data_q;
    assign irq           = irq_q;

endmodule

/* File: testbench/fds_regs_props.sv */
// Checker: port-level properties of the disk status register block
`timescale 1ns/1ps
module fds_regs_props
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  drv_present,
    input wire logic [1:0]  drv_powered,
    input wire logic [1:0]  drv_spun_up,
    input wire logic        op_start,
    input wire logic [2:0]  op_code,
    input wire logic        op_unit,
    input wire logic [6:0]  op_track,
    input wire logic [4:0]  op_sector,
    input wire logic        wr_word_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completing accesses; refused data writes must leave no trace
    wire       acc    = psel && penable && pready;
    wire       rd_ctl = acc && !pwrite && paddr == fds_pkg::OFF_CTRL;
    wire       go_w   = acc && pwrite && pwdata[0] &&
                        paddr == fds_pkg::OFF_CTRL;
    wire       wd_w   = acc && pwrite && !pslverr &&
                        paddr == fds_pkg::OFF_DATA;
    wire [1:0] rdy    = drv_present & drv_powered & drv_spun_up;

    a_start_addr: assert property (
        op_start && op_code inside {3'h2, 3'h3, 3'h6} |->
        op_track <= 7'h4C && op_sector inside {[5'h01:5'h1A]})
        else $error("drive launched with bad address");
    a_start_ready: assert property (
        op_start |-> rdy[op_unit])
        else $error("drive launched while not ready");
    a_start_cause: assert property (
        op_start |-> $past(go_w) || $past(go_w, 2))
        else $error("launch without a go write");
    a_start_pulse: assert property (
        op_start |=> !op_start)
        else $error("launch pulse too long");
    a_word_cause: assert property (
        wr_word_valid |-> $past(wd_w) || $past(wd_w, 2))
        else $error("word sent without a data write");
    a_strobe_refuse: assert property (
        acc && pwrite && pstrb[1:0] != 2'h3 |-> pslverr)
        else $error("partial word write accepted");
    a_addr_zeros: assert property (
        acc && !pwrite && paddr == fds_pkg::OFF_ADDR |->
        prdata[31:15] == 17'h0 && prdata[7:5] == 3'h0)
        else $error("address register spare bits not zero");
    a_err_done: assert property (
        rd_ctl && prdata[15] |-> prdata[7])
        else $error("error summary without done");
    a_func_wo: assert property (
        rd_ctl |-> prdata[3:0] == 4'h0)
        else $error("write-only control bits read back");

    c_launch: cover property (op_start);
    c_refused: cover property (rd_ctl && prdata[15]);
    c_word: cover property (wr_word_valid);
endmodule

bind fds_regs fds_regs_props u_fds_regs_props (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .drv_present, .drv_powered, .drv_spun_up, .op_start, .op_code,
    .op_unit, .op_track, .op_sector, .wr_word_valid);

/* File: testbench/fds_drive_model.sv */
// Drive-side model: answers launched functions promptly or slowly
`timescale 1ns/1ps
module fds_drive_model
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        op_start,
    input  wire logic [2:0]  op_code,
    input  wire logic [3:0]  fault,
    input  wire logic        slow,
    output logic             op_done,
    output logic             op_deleted,
    output logic             op_not_found,
    output logic             op_crc_bad,
    output logic             op_lost_data,
    output logic             rd_word_valid,
    output logic [15:0]      rd_word
);
    logic [3:0] cnt_q;
    logic       tgl_q;

    // Busy count; the toggle keeps unqualified lines from looking valid
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 4'h0;
            tgl_q <= 1'b0;
        end
        else
        begin
            tgl_q <= ~tgl_q;
            if (op_start)
                cnt_q <= slow ? 4'hE : 4'h3;
            else if (cnt_q != 4'h0)
                cnt_q <= cnt_q - 4'h1;
        end
    end

    // Fault flags carry meaning only beside done
    assign op_done       = cnt_q == 4'h1;
    assign op_deleted    = op_done ? fault[0] : tgl_q;
    assign op_not_found  = op_done ? fault[1] : tgl_q;
    assign op_crc_bad    = op_done ? fault[2] : tgl_q;
    assign op_lost_data  = op_done ? fault[3] : tgl_q;
    // One whole word handed back during a read
    assign rd_word_valid = cnt_q == 4'h2 && op_code == 3'h3;
    assign rd_word       = rd_word_valid ? 16'hA5C3 : {16{tgl_q}};
endmodule

/* File: testbench/fds_regs_test.sv */
// Self-checking bench for the disk status register block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module fds_regs_test;
    logic        pclk, presetn, psel, penable, pwrite, slow, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [3:0]  pstrb, fault;
    logic [1:0]  pres, pwr, spun;
    logic [15:0] cs;
    logic [31:0] ba [3] = '{32'h0000, 32'h001B, 32'h4D01};
    wire  [31:0] prdata;
    wire         pready, pslverr, op_start, op_unit, op_done, irq;
    wire         op_deleted, op_not_found, op_crc_bad, op_lost_data;
    wire         wr_word_valid, rd_word_valid;
    wire  [2:0]  op_code;
    wire  [6:0]  op_track;
    wire  [4:0]  op_sector;
    wire  [15:0] wr_word, rd_word;
    int          failures, comparisons;

    fds_regs u_fds_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .drv_present(pres),
        .drv_powered(pwr), .drv_spun_up(spun), .op_start, .op_code, .op_unit,
        .op_track, .op_sector, .op_done, .op_deleted, .op_not_found,
        .op_crc_bad, .op_lost_data, .wr_word_valid, .wr_word, .rd_word_valid,
        .rd_word, .irq);
    fds_drive_model u_fds_drive_model (.pclk, .presetn, .op_start, .op_code,
        .fault, .slow, .op_done, .op_deleted, .op_not_found, .op_crc_bad,
        .op_lost_data, .rd_word_valid, .rd_word);

    always #2.5 pclk = ~pclk;

    // One APB transfer; waits for pready without assuming a latency
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            failures++;
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Launch a function with irq enable, poll done, then fetch the data word
    task automatic go(input logic [2:0] c, input logic u);
        int k;
        apb(1'b1, fds_pkg::OFF_CTRL, {25'h0, 1'b1, 1'b0, u, c, 1'b1});
        k = 0;
        do
        begin
            apb(1'b0, fds_pkg::OFF_CTRL, 32'h0);
            k++;
        end
        while (rd[7] !== 1'b1 && k < 40);
        cs = rd[15:0];
        apb(1'b0, fds_pkg::OFF_DATA, 32'h0);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard, far beyond the expected run length
    initial
    begin
        #100000;
        failures++;
        give_verdict();
    end

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, slow} = 6'h0;
        {paddr, pwdata, pstrb, fault} = {12'h0, 32'h0, 4'hF, 4'h0};
        {pres, pwr, spun} = 6'h3D;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, fds_pkg::OFF_CTRL, 32'h0);
        `CHK(rd[15:0], fds_pkg::CTRL_RESET)
        $display("test reset done");
        apb(1'b1, fds_pkg::OFF_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, fds_pkg::OFF_ADDR, 32'h0);
        `CHK(rd, 32'h0000_7F1F)
        `CHK({op_track, op_sector}, 12'hFFF)
        apb(1'b1, fds_pkg::OFF_DATA, 32'h0000_1234);
        pstrb <= 4'h1;
        apb(1'b1, fds_pkg::OFF_DATA, 32'h0000_5678);
        pstrb <= 4'hF;
        `CHK(er, 1'b1)
        apb(1'b0, fds_pkg::OFF_DATA, 32'h0);
        `CHK(rd, 32'h0000_1234)
        `CHK(wr_word, 16'h1234)
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK(er, 1'b1)
        $display("test registers done");
        go(fds_pkg::FN_INIT, 1'b0);
        `CHK(cs, 16'h00C0)
        `CHK(rd[15:0], 16'h0081)
        // Knock out each ready condition of unit 1 in turn, then none
        for (int i = 0; i < 4; i++)
        begin
            {pres, pwr, spun} <= 6'h3F ^ (i < 3 ? 6'h02 << (2 * i) : 6'h00);
            go(fds_pkg::FN_STATUS, 1'b1);
            `CHK(rd[15:0], i < 3 ? 16'h0000 : 16'h0080)
            `CHK(cs[15], i < 3 ? 1'b1 : 1'b0)
        end
        $display("test ready done");
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, fds_pkg::OFF_ADDR, ba[i]);
            go(fds_pkg::FN_READ, 1'b0);
            `CHK(rd[15:0] & 16'hFF7F, 16'h0002)
            `CHK(cs[15], 1'b1)
        end
        apb(1'b1, fds_pkg::OFF_ADDR, 32'h0000_4C1A);
        for (int c = 0; c < 8; c++)
        begin
            go(3'(c), 1'b0);
            `CHK(cs, 16'h00C0)
        end
        $display("test functions done");
        slow <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            fault <= 4'h1 << i;
            go(i == 1 ? fds_pkg::FN_WRITE : fds_pkg::FN_READ, 1'b0);
            `CHK(rd[15:0] & 16'hFF7F, 16'h0020 >> i)
            `CHK(cs[15], 1'b1)
        end
        fault <= 4'h0;
        $display("test faults done");
        `CHK(irq, 1'b0)
        apb(1'b1, fds_pkg::OFF_IMASK, 32'h3);
        apb(1'b0, fds_pkg::OFF_IMASK, 32'h0);
        `CHK(irq, 1'b1)
        apb(1'b0, fds_pkg::OFF_ISTAT, 32'h0);
        `CHK(rd[1:0], 2'h3)
        apb(1'b0, fds_pkg::OFF_CTRL, 32'h0);
        `CHK(irq, 1'b0)
        go(fds_pkg::FN_FILL, 1'b0);
        `CHK(irq, 1'b1)
        $display("test interrupt done");
        give_verdict();
    end
endmodule
